// *** src/scr_boot_config_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz mclk, APB byte addressing
// Notes:   Included by the package, the monitor and the bench
`ifndef SCR_BOOT_CONFIG_CFG_SVH
`define SCR_BOOT_CONFIG_CFG_SVH

// Register byte offsets
`define SCR_ADDR_STATUS   8'h00
`define SCR_ADDR_CONTROL  8'h04
`define SCR_ADDR_SLOTCLK  8'h08

// Control fields
`define SCR_CTL_FUND_RST  0
`define SCR_CTL_HOT_RST   1
`define SCR_CTL_HALT      2
`define SCR_CTL_AUXDIS_N  3

// Slot clock fields
`define SCR_SLOT_UP       0
`define SCR_SLOT_DS_LSB   1

// Status fields
`define SCR_STS_PHASE_LSB 16
`define SCR_STS_COLD      20
`define SCR_STS_RSVD_MODE 21

// Port count, mode codes
`define SCR_NUM_DS        4
`define SCR_MODE_NORMAL   3'h0
`define SCR_MODE_CFGMEM   3'h1

// Reset values
`define SCR_RST_HALT      1'b0
`define SCR_RST_AUXDIS_N  1'b0
`define SCR_RST_SLOT      1'b1

// Clock figures in MHz
`define SCR_REF_LOW_MHZ   100
`define SCR_REF_HIGH_MHZ  125
`define SCR_SERDES_MHZ    2500
`define SCR_CORE_MHZ      250
`define SCR_PLL_FB_LOW    (`SCR_SERDES_MHZ / `SCR_REF_LOW_MHZ)
`define SCR_PLL_FB_HIGH   (`SCR_SERDES_MHZ / `SCR_REF_HIGH_MHZ)
`define SCR_PLL_CORE_DIV  (`SCR_SERDES_MHZ / `SCR_CORE_MHZ)

// Management bus rates in kHz
`define SCR_MCLK_KHZ      25000
`define SCR_MBUS_SLOW_KHZ 100
`define SCR_MBUS_FAST_KHZ 400
`define SCR_MBUS_SLOW_CYC \
  ((`SCR_MCLK_KHZ + `SCR_MBUS_SLOW_KHZ - 1) / `SCR_MBUS_SLOW_KHZ)
`define SCR_MBUS_FAST_CYC \
  ((`SCR_MCLK_KHZ + `SCR_MBUS_FAST_KHZ - 1) / `SCR_MBUS_FAST_KHZ)

`endif

// *** src/scr_pkg.sv ***
// Purpose: Types of the clock, reset and boot configuration block
// Assumes: Constants come from the cfg header
// Notes:   None
`include "scr_boot_config_cfg.svh"

package scr_pkg;

  // Boot strap vector
  typedef struct packed {
    logic       auxDisN;
    logic [2:0] mode;
    logic       halt;
    logic       slow;
    logic       refSel;
    logic       ccUs;
    logic       ccDs;
  } scr_strap_t;

  typedef enum logic [2:0] {
    PH_FUND, PH_INIT, PH_HALT, PH_RUN, PH_HOT
  } scr_phase_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } scr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } scr_apb_rsp_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
  } scr_cfg_wr_t;

  typedef struct packed {
    logic                   coreReset;
    logic                   regReset;
    logic                   hotReset;
    logic                   stickyClear;
    logic                   vbusHotReset;
    logic [`SCR_NUM_DS-1:0] dsLinkHotReset;
    logic                   fundCold;
    logic                   mgmtBusEn;
  } scr_rst_t;

  typedef struct packed {
    logic                   perstMeta;
    logic                   perst;
    scr_strap_t             strapMeta;
    scr_strap_t             strapSync;
    scr_phase_t             phase;
    logic                   fromPin;
    logic                   coldPending;
    logic                   fundCold;
    scr_strap_t             work;
    scr_strap_t             coldSnap;
    logic                   ctlHalt;
    logic                   ctlAuxDisN;
    logic                   fundReq;
    logic                   hotReq;
    logic                   slotUp;
    logic [`SCR_NUM_DS-1:0] slotDs;
    logic [31:0]            prdata;
    logic                   addrBad;
    logic [7:0]             tickCnt;
    logic                   tick;
    logic                   initStart;
    logic                   stickyClr;
  } scr_st_t;

endpackage : scr_pkg

// *** src/scr_boot_config.sv ***
// Purpose: Clock select, boot strap capture and reset sequencing
// Assumes: Straps and platform reset are asynchronous pins
// Notes:   Registers over APB, config memory writes on a side port
`timescale 1ns/1ps

module scr_boot_config (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // Pins
  input  wire logic                   platformResetN,
  input  wire scr_pkg::scr_strap_t    strapPins,
  // Reset requests from link and bridge logic
  input  wire logic                   linkHotReq,
  input  wire logic                   upBusReset,
  input  wire logic [`SCR_NUM_DS-1:0] dsBusReset,
  // Config memory loader
  input  wire scr_pkg::scr_cfg_wr_t   cfgWr,
  input  wire logic                   cfgDone,
  input  wire logic                   cfgError,
  output logic                        cfgInitStart,
  // APB slave
  input  wire scr_pkg::scr_apb_req_t  apbReq,
  output scr_pkg::scr_apb_rsp_t       apbRsp,
  // Reset outputs
  output scr_pkg::scr_rst_t           rstOut,
  // Clock and mode outputs
  output logic                        refFreqHigh,
  output logic [7:0]                  pllFbDiv,
  output logic [7:0]                  pllCoreDiv,
  output logic                        masterBusSlow,
  output logic                        masterBusTick,
  output logic                        auxPowerEn,
  output logic                        modeReserved,
  output logic                        slotClkUp,
  output logic [`SCR_NUM_DS-1:0]      slotClkDs
);

  //**************************************************************
  // Helpers
  //**************************************************************
  scr_pkg::scr_st_t st;
  scr_pkg::scr_st_t next_st;
  scr_pkg::scr_strap_t ws;
  logic apbWr;
  logic apbSetup;

  function automatic logic isReserved(input logic [2:0] mode);
    isReserved = (mode != `SCR_MODE_NORMAL) &&
                 (mode != `SCR_MODE_CFGMEM);
  endfunction : isReserved

  // Register write shared by APB and config memory
  function automatic scr_pkg::scr_st_t writeReg(
    input scr_pkg::scr_st_t s,
    input logic [7:0]       addr,
    input logic [31:0]      data,
    input logic             fromCfg
  );
    scr_pkg::scr_st_t r;
    r = s;
    case (addr)
      `SCR_ADDR_STATUS: begin
        if (fromCfg) begin
          r.coldSnap = data[8:0];
        end
      end
      `SCR_ADDR_CONTROL: begin
        r.fundReq    = s.fundReq | data[`SCR_CTL_FUND_RST];
        r.hotReq     = s.hotReq | data[`SCR_CTL_HOT_RST];
        r.ctlHalt    = data[`SCR_CTL_HALT];
        r.ctlAuxDisN = data[`SCR_CTL_AUXDIS_N];
      end
      `SCR_ADDR_SLOTCLK: begin
        r.slotUp = data[`SCR_SLOT_UP];
        r.slotDs = data[`SCR_SLOT_DS_LSB +: `SCR_NUM_DS];
      end
      default: begin
        r = s;
      end
    endcase
    return r;
  endfunction : writeReg

  function automatic logic [32:0] readReg(
    input scr_pkg::scr_st_t s,
    input logic [7:0]       addr
  );
    logic [31:0] d;
    logic        bad;
    d   = 32'h0000_0000;
    bad = 1'b0;
    case (addr)
      `SCR_ADDR_STATUS: begin
        d[8:0] = s.coldSnap;
        d[`SCR_STS_PHASE_LSB +: 3] = s.phase;
        d[`SCR_STS_COLD] = s.fundCold;
        d[`SCR_STS_RSVD_MODE] = isReserved(s.work.mode);
      end
      `SCR_ADDR_CONTROL: begin
        d[`SCR_CTL_HALT]     = s.ctlHalt;
        d[`SCR_CTL_AUXDIS_N] = s.ctlAuxDisN;
      end
      `SCR_ADDR_SLOTCLK: begin
        d[`SCR_SLOT_UP] = s.slotUp;
        d[`SCR_SLOT_DS_LSB +: `SCR_NUM_DS] = s.slotDs;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    return {bad, d};
  endfunction : readReg

  assign apbSetup = apbReq.psel & ~apbReq.penable;
  assign apbWr    = apbReq.psel & apbReq.penable & apbReq.pwrite;

  //**************************************************************
  // Next state
  //**************************************************************
  always_comb begin
    next_st = st;
    ws      = st.fromPin ? st.strapSync : st.work;
    // Pin synchronisers
    next_st.perstMeta = platformResetN;
    next_st.perst     = st.perstMeta;
    next_st.strapMeta = strapPins;
    next_st.strapSync = st.strapMeta;
    next_st.initStart = 1'b0;
    next_st.stickyClr = 1'b0;

    // Register writes, APB last so it wins a same-cycle clash
    if (cfgWr.en) begin
      next_st = writeReg(next_st, cfgWr.addr, cfgWr.data, 1'b1);
    end
    if (apbWr) begin
      next_st = writeReg(next_st, apbReq.paddr, apbReq.pwdata, 1'b0);
    end
    if (apbSetup) begin
      {next_st.addrBad, next_st.prdata} = readReg(st, apbReq.paddr);
    end

    // Load error sets halt, winning over a clear
    if (st.phase == scr_pkg::PH_INIT && cfgError) begin
      next_st.ctlHalt = 1'b1;
    end

    // Master bus bit-rate divider
    next_st.tick = 1'b0;
    if (st.phase == scr_pkg::PH_FUND) begin
      next_st.tickCnt = 8'h00;
    end else if (st.tickCnt == 8'h00) begin
      next_st.tick    = 1'b1;
      next_st.tickCnt = st.work.slow ?
        8'(`SCR_MBUS_SLOW_CYC - 1) : 8'(`SCR_MBUS_FAST_CYC - 1);
    end else begin
      next_st.tickCnt = st.tickCnt - 8'h01;
    end

    // Reset sequencer
    case (st.phase)
      scr_pkg::PH_FUND: begin
        if (st.perst) begin
          if (st.fromPin) begin
            next_st.work = st.strapSync;
            if (st.coldPending) begin
              next_st.coldSnap = st.strapSync;
            end
          end
          next_st.fundCold    = st.fromPin & st.coldPending;
          next_st.coldPending = st.coldPending & ~st.fromPin;
          next_st.ctlHalt     = ws.halt;
          next_st.ctlAuxDisN  = ws.auxDisN;
          next_st.slotUp      = ws.ccUs;
          next_st.slotDs      = {`SCR_NUM_DS{ws.ccDs}};
          next_st.stickyClr   = ~ws.auxDisN;
          next_st.fundReq     = 1'b0;
          next_st.hotReq      = 1'b0;
          if (ws.mode == `SCR_MODE_CFGMEM) begin
            next_st.phase     = scr_pkg::PH_INIT;
            next_st.initStart = 1'b1;
          end else if (ws.halt) begin
            next_st.phase = scr_pkg::PH_HALT;
          end else begin
            next_st.phase = scr_pkg::PH_RUN;
          end
        end
      end
      scr_pkg::PH_INIT: begin
        if (cfgDone || cfgError) begin
          next_st.phase = next_st.ctlHalt ?
            scr_pkg::PH_HALT : scr_pkg::PH_RUN;
        end
      end
      scr_pkg::PH_HALT: begin
        if (!st.ctlHalt) begin
          next_st.phase = scr_pkg::PH_RUN;
        end
      end
      scr_pkg::PH_RUN: begin
        if (linkHotReq || st.hotReq) begin
          next_st.phase  = scr_pkg::PH_HOT;
          next_st.hotReq = 1'b0;
        end
      end
      scr_pkg::PH_HOT: begin
        if (!linkHotReq) begin
          if (st.work.mode == `SCR_MODE_CFGMEM) begin
            next_st.phase     = scr_pkg::PH_INIT;
            next_st.initStart = 1'b1;
          end else begin
            next_st.phase = scr_pkg::PH_RUN;
          end
        end
      end
      default: begin
        next_st.phase = scr_pkg::PH_FUND;
      end
    endcase

    // Fundamental reset sources take priority
    if (!st.perst) begin
      next_st.phase   = scr_pkg::PH_FUND;
      next_st.fromPin = 1'b1;
    end else if (st.fundReq && st.phase != scr_pkg::PH_FUND) begin
      next_st.phase   = scr_pkg::PH_FUND;
      next_st.fromPin = 1'b0;
      next_st.fundReq = 1'b0;
    end
  end

  //**************************************************************
  // State register
  //**************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      st             <= '0;
      st.phase       <= scr_pkg::PH_FUND;
      st.fromPin     <= 1'b1;
      st.coldPending <= 1'b1;
      st.ctlHalt     <= `SCR_RST_HALT;
      st.ctlAuxDisN  <= `SCR_RST_AUXDIS_N;
      st.slotUp      <= `SCR_RST_SLOT;
      st.slotDs      <= {`SCR_NUM_DS{`SCR_RST_SLOT}};
    end else begin
      st <= next_st;
    end
  end

  //**************************************************************
  // Outputs
  //**************************************************************
  always_comb begin
    apbRsp.prdata  = st.prdata;
    apbRsp.pready  = apbReq.psel & apbReq.penable;
    apbRsp.pslverr = apbReq.psel & apbReq.penable & st.addrBad;
  end

  always_comb begin
    rstOut.coreReset    = (st.phase != scr_pkg::PH_RUN);
    rstOut.regReset     = (st.phase == scr_pkg::PH_FUND);
    rstOut.hotReset     = (st.phase == scr_pkg::PH_HOT);
    rstOut.stickyClear  = st.stickyClr;
    rstOut.vbusHotReset = rstOut.hotReset | upBusReset;
    rstOut.fundCold     = st.fundCold;
    rstOut.mgmtBusEn    = (st.phase != scr_pkg::PH_FUND);
  end

  genvar g;
  generate
    for (g = 0; g < `SCR_NUM_DS; g++) begin : gDsHot
      assign rstOut.dsLinkHotReset[g] =
        dsBusReset[g] | rstOut.hotReset;
    end
  endgenerate

  assign refFreqHigh   = st.work.refSel;
  assign pllFbDiv      = st.work.refSel ?
    8'(`SCR_PLL_FB_HIGH) : 8'(`SCR_PLL_FB_LOW);
  assign pllCoreDiv    = 8'(`SCR_PLL_CORE_DIV);
  assign masterBusSlow = st.work.slow;
  assign masterBusTick = st.tick;
  assign auxPowerEn    = st.ctlAuxDisN;
  assign modeReserved  = isReserved(st.work.mode);
  assign cfgInitStart  = st.initStart;
  assign slotClkUp     = st.slotUp;
  assign slotClkDs     = st.slotDs;

endmodule : scr_boot_config

// *** verif/scr_boot_config_monitor.sv ***
// Purpose: Port-level checks of the boot configuration block
// Assumes: One clock domain, srst synchronous active high
// Notes:   Bound to the design from tb_top
`timescale 1ns/1ps
`include "scr_boot_config_cfg.svh"

module scr_boot_config_monitor (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   srst,
  // Inputs watched
  input wire logic                   upBusReset,
  input wire logic [`SCR_NUM_DS-1:0] dsBusReset,
  input wire scr_pkg::scr_apb_req_t  apbReq,
  // Outputs watched
  input wire scr_pkg::scr_apb_rsp_t  apbRsp,
  input wire scr_pkg::scr_rst_t      rstOut,
  input wire logic                   cfgInitStart,
  input wire logic                   refFreqHigh,
  input wire logic [7:0]             pllFbDiv,
  input wire logic [7:0]             pllCoreDiv,
  input wire logic                   masterBusSlow,
  input wire logic                   masterBusTick,
  input wire logic                   modeReserved
);
  // ****************************************
  // Gap between master bus ticks
  // ****************************************
  logic [7:0] gap;
  logic       gapValid;
  logic [7:0] gapLim;
  assign gapLim = masterBusSlow ? 8'hf9 : 8'h3e;
  always_ff @(posedge mclk) begin
    if (srst || rstOut.regReset) begin
      gap      <= 8'h00;
      gapValid <= 1'b0;
    end else if (masterBusTick) begin
      gap      <= 8'h00;
      gapValid <= 1'b1;
    end else begin
      gap      <= gap + 8'h01;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_fb_div;
    pllFbDiv == (refFreqHigh ? 8'h14 : 8'h19);
  endproperty
  a_fb_div: assert property (p_fb_div)
    else $error("feedback divider wrong for reference select");
  property p_core_div;
    pllCoreDiv == 8'h0a;
  endproperty
  a_core_div: assert property (p_core_div)
    else $error("core divider wrong");
  property p_vbus;
    rstOut.vbusHotReset == (rstOut.hotReset | upBusReset);
  endproperty
  a_vbus: assert property (p_vbus)
    else $error("virtual bus hot reset wrong");
  property p_ds_link;
    rstOut.dsLinkHotReset == (dsBusReset | {`SCR_NUM_DS{rstOut.hotReset}});
  endproperty
  a_ds_link: assert property (p_ds_link)
    else $error("downstream link hot reset wrong");
  property p_strap_hold;
    !$past(rstOut.regReset) |->
      $stable({refFreqHigh, masterBusSlow, modeReserved});
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap outputs moved outside fundamental reset");
  property p_mgmt;
    rstOut.mgmtBusEn == !rstOut.regReset;
  endproperty
  a_mgmt: assert property (p_mgmt)
    else $error("management bus enable wrong");
  property p_hot_core;
    rstOut.hotReset || rstOut.regReset |-> rstOut.coreReset;
  endproperty
  a_hot_core: assert property (p_hot_core)
    else $error("core not held in reset");
  property p_init;
    cfgInitStart |-> !modeReserved ##1 !cfgInitStart;
  endproperty
  a_init: assert property (p_init)
    else $error("config load start wrong");
  property p_tick;
    gapValid && !rstOut.regReset |->
      (gap < gapLim) || (masterBusTick && gap == gapLim);
  endproperty
  a_tick: assert property (p_tick)
    else $error("master bus tick spacing wrong");
  property p_apb;
    apbRsp.pready == (apbReq.psel && apbReq.penable) &&
      (!apbRsp.pslverr || apbRsp.pready);
  endproperty
  a_apb: assert property (p_apb)
    else $error("bus answer outside access phase");

  c_run: cover property ($fell(rstOut.coreReset));
  c_init: cover property (cfgInitStart);
  c_hot: cover property ($rose(rstOut.hotReset));
endmodule : scr_boot_config_monitor

// *** verif/scr_board_model.sv ***
// Purpose: Board strap pins and platform reset source
// Assumes: Pins change just after a clock edge
// Notes:   Straps are always driven by the board
`timescale 1ns/1ps

module scr_board_model (
  // Clock
  input wire logic                 mclk,
  // Requests from the bench
  input wire logic                 resetReq,
  input wire scr_pkg::scr_strap_t  strapReq,
  // Pins
  output logic                     platformResetN,
  output scr_pkg::scr_strap_t      strapPins,
  output logic                     sscOff
);
  initial begin
    platformResetN = 1'b0;
    strapPins      = 9'h000;
  end
  always @(posedge mclk) begin
    platformResetN <= !resetReq;
    strapPins      <= strapReq;
  end
  // Spread spectrum off unless both ends share a clock
  assign sscOff = !(strapPins.ccUs && strapPins.ccDs);
endmodule : scr_board_model

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench of the boot configuration block
// Assumes: 25 MHz mclk, zero wait APB
// Notes:   Cold, soft, warm, reserved mode and hot reset runs
`timescale 1ns/1ps
`include "scr_boot_config_cfg.svh"

module tb_top;
  logic                   mclk, srst, resetReq, platformResetN, sscOff;
  logic                   linkHotReq, upBusReset, cfgDone, cfgError;
  logic                   cfgInitStart, refFreqHigh, masterBusSlow;
  logic                   masterBusTick, auxPowerEn, modeReserved;
  logic                   slotClkUp;
  logic [`SCR_NUM_DS-1:0] dsBusReset, slotClkDs;
  logic [7:0]             pllFbDiv, pllCoreDiv;
  scr_pkg::scr_strap_t    strapReq, strapPins;
  scr_pkg::scr_cfg_wr_t   cfgWr;
  scr_pkg::scr_apb_req_t  apbReq;
  scr_pkg::scr_apb_rsp_t  apbRsp;
  scr_pkg::scr_rst_t      rstOut;
  int                     nErrors, checked, initCnt, stickyCnt, regCnt;
  localparam scr_pkg::scr_strap_t strapA = 9'h105;
  localparam scr_pkg::scr_strap_t strapB = 9'h03a;
  localparam scr_pkg::scr_strap_t strapC = 9'h147;

  scr_board_model board (.mclk(mclk), .resetReq(resetReq),
    .strapReq(strapReq), .platformResetN(platformResetN),
    .strapPins(strapPins), .sscOff(sscOff));
  scr_boot_config dut (.mclk(mclk), .srst(srst),
    .platformResetN(platformResetN), .strapPins(strapPins),
    .linkHotReq(linkHotReq), .upBusReset(upBusReset),
    .dsBusReset(dsBusReset), .cfgWr(cfgWr), .cfgDone(cfgDone),
    .cfgError(cfgError), .cfgInitStart(cfgInitStart), .apbReq(apbReq),
    .apbRsp(apbRsp), .rstOut(rstOut), .refFreqHigh(refFreqHigh),
    .pllFbDiv(pllFbDiv), .pllCoreDiv(pllCoreDiv),
    .masterBusSlow(masterBusSlow), .masterBusTick(masterBusTick),
    .auxPowerEn(auxPowerEn), .modeReserved(modeReserved),
    .slotClkUp(slotClkUp), .slotClkDs(slotClkDs));

  // ****************************************
  // Clock, event counters, tasks
  // ****************************************
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    initCnt   <= initCnt + 32'(cfgInitStart === 1'b1);
    stickyCnt <= stickyCnt + 32'(rstOut.stickyClear === 1'b1);
    regCnt    <= regCnt + 32'(rstOut.regReset === 1'b1);
  end

  task automatic testDone();
    $display("Checks %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : testDone

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge mclk);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr,
                pwdata: d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (apbRsp.pready !== 1'b1) begin
      nErrors++;
      $display("Error apb pready expected 1 seen %b", apbRsp.pready);
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, exp, rd);
    chk({what, " slverr"}, {31'h0, expErr}, {31'h0, err});
  endtask : rdChk

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step

  task automatic waitRun();
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge mclk);
      #1;
      if (rstOut.coreReset === 1'b0) break;
    end
  endtask : waitRun

  task automatic pinReset(input scr_pkg::scr_strap_t s);
    @(posedge mclk);
    resetReq <= 1'b1;
    strapReq <= s;
    step(4);
    resetReq <= 1'b0;
  endtask : pinReset

  function automatic logic [31:0] sts(scr_pkg::scr_strap_t s,
      logic [2:0] ph, logic cold, logic rsv);
    return {10'h0, rsv, cold, 1'b0, ph, 7'h0, s};
  endfunction : sts

  function automatic logic [31:0] outs();
    return {15'h0, slotClkUp, slotClkDs, masterBusSlow, auxPowerEn,
            refFreqHigh, modeReserved, pllFbDiv};
  endfunction : outs

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    srst = 1'b1; resetReq = 1'b1; strapReq = strapA;
    linkHotReq = 1'b0; upBusReset = 1'b0; dsBusReset = '0;
    cfgWr = '0; cfgDone = 1'b0; cfgError = 1'b0; apbReq = '0;
    nErrors = 0; checked = 0; initCnt = 0; stickyCnt = 0; regCnt = 0;
    step(2);
    srst <= 1'b0;
    step(3);
    resetReq <= 1'b0;
    waitRun();
    chk("cold outs", {15'h0, 5'h0f, 4'b0110, 8'h14}, outs());
    chk("core div", 32'h0a, {24'h0, pllCoreDiv});
    chk("ssc off", 32'h1, {31'h0, sscOff});
    chk("cold", 32'h1, {31'h0, rstOut.fundCold});
    rdChk("status", 8'h00, sts(strapA, 3'h3, 1'b1, 1'b0), 1'b0);
    rdChk("control", 8'h04, 32'h8, 1'b0);
    strapReq <= strapB;
    step(10);
    #1 chk("pins ignored", {15'h0, 5'h0f, 4'b0110, 8'h14}, outs());
    wr(8'h08, 32'h1);
    rdChk("slot", 8'h08, 32'h1, 1'b0);
    wr(8'h00, 32'hffffffff);
    rdChk("status ro", 8'h00, sts(strapA, 3'h3, 1'b1, 1'b0), 1'b0);
    rdChk("unmapped", 8'h0c, 32'h0, 1'b1);
    regCnt = 0;
    wr(8'h04, 32'h9);
    step(4);
    #1 chk("soft outs", {15'h0, 5'h0f, 4'b0110, 8'h14}, outs());
    chk("soft fund", 32'h1, {31'h0, regCnt > 0});
    rdChk("warm status", 8'h00, sts(strapA, 3'h3, 1'b0, 1'b0), 1'b0);
    pinReset(strapB);
    for (int i = 0; i < 20 && initCnt == 0; i++) step(1);
    cfgWr <= '{en: 1'b1, addr: 8'h08, data: 32'h1e};
    step(1);
    cfgWr <= '0;
    cfgDone <= 1'b1;
    step(1);
    cfgDone <= 1'b0;
    step(3);
    #1 chk("halt outs", {15'h0, 5'h0f, 4'b1000, 8'h19}, outs());
    chk("halted", 32'h3, {30'h0, rstOut.coreReset, rstOut.mgmtBusEn});
    chk("loads", 32'h11, {initCnt[3:0], stickyCnt[3:0]});
    rdChk("halt ctl", 8'h04, 32'h4, 1'b0);
    rdChk("halt status", 8'h00, sts(strapA, 3'h2, 1'b0, 1'b0), 1'b0);
    step(520);
    wr(8'h04, 32'h0);
    waitRun();
    chk("halt left", 32'h0, {31'h0, rstOut.coreReset});
    step(520);
    pinReset(strapC);
    waitRun();
    chk("rsvd outs", {15'h0, 5'h1f, 4'b0111, 8'h14}, outs());
    chk("no load", 32'h1, initCnt);
    linkHotReq <= 1'b1;
    step(3);
    #1 chk("hot", 32'h1f, {rstOut.hotReset, rstOut.dsLinkHotReset});
    step(1);
    linkHotReq <= 1'b0;
    waitRun();
    rdChk("hot ctl", 8'h04, 32'h8, 1'b0);
    step(1);
    upBusReset <= 1'b1;
    dsBusReset <= 4'h4;
    step(2);
    #1 chk("bus rst", 32'h14, {rstOut.vbusHotReset, rstOut.dsLinkHotReset});
    chk("up port", 32'h0, {31'h0, rstOut.coreReset});
    testDone();
  end

  initial begin
    step(6000);
    nErrors++;
    testDone();
  end
endmodule : tb_top

bind scr_boot_config scr_boot_config_monitor u_mon (.mclk(mclk),
  .srst(srst), .upBusReset(upBusReset), .dsBusReset(dsBusReset),
  .apbReq(apbReq), .apbRsp(apbRsp), .rstOut(rstOut),
  .cfgInitStart(cfgInitStart), .refFreqHigh(refFreqHigh),
  .pllFbDiv(pllFbDiv), .pllCoreDiv(pllCoreDiv),
  .masterBusSlow(masterBusSlow), .masterBusTick(masterBusTick),
  .modeReserved(modeReserved));
